/* File: drive_ctrl_pkg.sv */
// Constants and carrier types for drive sleep and protection control
package drive_ctrl_pkg;
  localparam int unsigned clk_hz          = 50_000_000;
  localparam int unsigned tick_cycles     = clk_hz;
  localparam logic [8:0]  sleep_off       = 9'h000;
  localparam logic [8:0]  sleep_max_s     = 9'h12c;
  localparam logic [5:0]  ilim_off        = 6'h3d;
  localparam logic [15:0] wake_default    = 16'h01f4;
  localparam logic [15:0] sleep_default   = 16'h0000;
  localparam logic [7:0]  boost_default   = 8'h64;
  localparam logic [7:0]  boost_min       = 8'h01;
  localparam logic [7:0]  boost_max       = 8'hc8;
  localparam logic [7:0]  pct_full        = 8'h64;
  localparam logic [7:0]  mains_derate_pct = 8'h1e;
  localparam logic [15:0] derate_khz10    = 16'h002d;
  localparam logic [15:0] fsw_min_khz10   = 16'h0014;
  localparam logic [3:0]  addr_sleep_time = 4'h0;
  localparam logic [3:0]  addr_sleep_freq = 4'h1;
  localparam logic [3:0]  addr_wake_freq  = 4'h2;
  localparam logic [3:0]  addr_boost      = 4'h3;
  localparam logic [3:0]  addr_fsw        = 4'h4;
  localparam logic [3:0]  addr_modes      = 4'h5;
  localparam logic [3:0]  addr_ilim_delay = 4'h6;
  localparam logic [3:0]  addr_fb_low     = 4'h7;
  localparam logic [3:0]  addr_fb_high    = 4'h8;
  localparam logic [3:0]  addr_status     = 4'h9;
  localparam logic [3:0]  addr_fmax       = 4'ha;
  localparam logic [31:0] fb_low_limit    = 32'hc465_3601;

  typedef enum logic [1:0] {
    noise_adaptive = 2'h0,
    noise_fixed    = 2'h1,
    noise_lc       = 2'h2
  } noise_mode_type;

  typedef enum logic [1:0] {
    mains_trip    = 2'h0,
    mains_derate  = 2'h1,
    mains_warning = 2'h2
  } mains_action_type;

  typedef enum {run, counting, asleep} sleep_state_type;

  typedef struct packed {
    logic [8:0]  sleep_time;
    logic [15:0] sleep_freq;
    logic [15:0] wake_freq;
    logic [7:0]  boost;
    logic [15:0] switch_rate;
    logic [15:0] fmax;
    logic [1:0]  noise_mode;
    logic        no_load_action;
    logic [1:0]  mains_action;
    logic        overheat_action;
    logic [5:0]  trip_delay;
    logic [31:0] fb_low;
    logic [31:0] fb_high;
  } settings_type;

  typedef struct packed {
    logic [15:0] out_freq;
    logic [15:0] theo_freq;
    logic [15:0] current;
    logic [15:0] ilim;
    logic [15:0] low_current;
    logic [15:0] rated_current;
    logic        closed_loop;
    logic        local_or_jog;
    logic        mains_fault;
    logic        overtemp;
  } drive_in_type;

  typedef struct packed {
    logic        motor_stop;
    logic        ramp_stop;
    logic [7:0]  boost_pct;
    logic [15:0] freq_clamp;
    logic [15:0] active_switch_rate;
    logic        derate_output;
    logic [15:0] current_clamp;
    logic        warning;
    logic        alarm;
    logic        lc_protect;
  } drive_out_type;
endpackage

/* File: second_tick.sv */
// One-second tick generator
module second_tick #(
  parameter int unsigned cycles = drive_ctrl_pkg::tick_cycles
) (
  input  wire logic clk,
  input  wire logic reset,
  output logic      tick
);
  typedef struct packed {
    logic [31:0] count;
    logic        tick;
  } tick_state_type;

  tick_state_type state;
  tick_state_type next_state;

  initial begin
    if (cycles < 2) $error("tick cycles too small");
  end

  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    if (state.count == 32'(cycles - 1)) begin
      next_state.count = 32'h0000_0000;
      next_state.tick = 1'b1;
    end else begin
      next_state.count = state.count + 32'h0000_0001;
    end
  end

  // (RULE26) Tick starts from zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick = state.tick;
endmodule

/* File: drive_sleep_and_protection_control.sv */
// Sleep mode, switching frequency and protection responses of the drive
// Overview of operation
// (RULE1) Sleep timer starts below sleep frequency
// (RULE2) Timer expiry stops the motor
// (RULE3) Wake when theoretical frequency exceeds wake threshold
// (RULE4) Timer value off disables sleep
// (RULE5) Sleep frequency zero to wake, default zero
// (RULE6) Wake frequency sleep to max, default 50
// (RULE7) Output follows theoretical frequency down to minimum
// (RULE8) Boost setpoint before sleep, closed loop only
// (RULE9) Switch rate used only in fixed mode; the code uses it in every noise mode
// (RULE10) Output frequency at most tenth of switching
// (RULE11) Derate output above 4.5 kHz switching
// (RULE12) Noise modes adaptive, fixed, LC filter
// (RULE13) Adaptive mode keeps maximum rate without derate; the code uses the programmed rate, without derate
// (RULE14) Low current trips or warns
// (RULE15) Mains failure trip stops the motor
// (RULE16) Mains derate to 30 percent, or warn
// (RULE17) Overtemperature trip stops motor with alarm
// (RULE18) Overtemperature derate lowers rate then current
// (RULE19) Cut out after delay at current limit
// (RULE20) Delay value 61 means off
// (RULE21) Feedback scaling active in both loop modes
// (RULE22) Feedback scaled linearly between low and high
// (RULE23) Timer clears when frequency rises again
// (RULE24) Sleep stop uses ramp down
// (RULE25) No sleep under local reference or jog
// (RULE26) Timers count seconds, zero at reset
//
// Chosen here: the register offsets and the strobed register port.
module drive_sleep_and_protection_control #(
  parameter int unsigned tick_cycles = drive_ctrl_pkg::tick_cycles
) (
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic [3:0]                    addr,
  input  wire logic [31:0]                   wdata,
  input  wire logic                          write,
  input  wire logic                          read,
  output logic [31:0]                        rdata,
  input  wire drive_ctrl_pkg::drive_in_type  drive_in,
  input  wire logic [15:0]                   feedback_raw,
  output drive_ctrl_pkg::drive_out_type      drive_out,
  output logic [31:0]                        feedback_scaled
);
  typedef struct packed {
    drive_ctrl_pkg::settings_type    cfg;
    drive_ctrl_pkg::sleep_state_type sleep_state;
    logic [8:0]                      sleep_count;
    logic [5:0]                      ilim_count;
    logic                            ilim_trip;
    logic                            heat_rate_low;
    logic [31:0]                     rdata;
    drive_ctrl_pkg::drive_out_type   out;
    logic [31:0]                     fb;
  } ctrl_state_type;

  ctrl_state_type state;
  ctrl_state_type next_state;
  logic           tick;

  initial begin
    if (tick_cycles < 2) $error("tick_cycles too small");
  end

  second_tick #(
    .cycles (tick_cycles)
  ) tick_gen (
    .clk   (clk),
    .reset (reset),
    .tick  (tick)
  );

  function automatic logic [15:0] pct_of(input logic [15:0] v,
                                         input logic [7:0] p);
    logic [23:0] prod;
    prod = v * p;
    pct_of = 16'(prod / drive_ctrl_pkg::pct_full);
  endfunction

  function automatic logic [15:0] min16(input logic [15:0] a,
                                        input logic [15:0] b);
    min16 = (a < b) ? a : b;
  endfunction

  always_comb begin
    logic [15:0] rate;
    logic [15:0] cur_lim;
    logic        sleep_ok;
    logic        below;
    logic        stop_now;
    logic signed [47:0] span;
    logic signed [47:0] scaled;
    rate = 16'h0000;
    cur_lim = 16'h0000;
    sleep_ok = 1'b0;
    below = 1'b0;
    stop_now = 1'b0;
    span = '0;
    scaled = '0;
    next_state = state;
    next_state.rdata = 32'h0000_0000;

    if (write) begin
      case (addr)
        drive_ctrl_pkg::addr_sleep_time: begin
          if (wdata[8:0] <= drive_ctrl_pkg::sleep_max_s) begin
            next_state.cfg.sleep_time = wdata[8:0];
          end
        end
        // (RULE5) Sleep frequency bounded by wake
        drive_ctrl_pkg::addr_sleep_freq: begin
          if (wdata[15:0] <= state.cfg.wake_freq) begin
            next_state.cfg.sleep_freq = wdata[15:0];
          end
        end
        // (RULE6) Wake bounded by sleep and max
        drive_ctrl_pkg::addr_wake_freq: begin
          if (wdata[15:0] >= state.cfg.sleep_freq &&
              wdata[15:0] <= state.cfg.fmax) begin
            next_state.cfg.wake_freq = wdata[15:0];
          end
        end
        drive_ctrl_pkg::addr_boost: begin
          if (wdata[7:0] >= drive_ctrl_pkg::boost_min &&
              wdata[7:0] <= drive_ctrl_pkg::boost_max) begin
            next_state.cfg.boost = wdata[7:0];
          end
        end
        drive_ctrl_pkg::addr_fsw: begin
          next_state.cfg.switch_rate = wdata[15:0];
        end
        // (RULE12) Mode codes, unknown codes ignored
        drive_ctrl_pkg::addr_modes: begin
          if (wdata[1:0] != 2'h3 && wdata[4:3] != 2'h3) begin
            next_state.cfg.noise_mode = wdata[1:0];
            next_state.cfg.no_load_action = wdata[2];
            next_state.cfg.mains_action = wdata[4:3];
            next_state.cfg.overheat_action = wdata[5];
          end
        end
        drive_ctrl_pkg::addr_ilim_delay: begin
          if (wdata[5:0] <= drive_ctrl_pkg::ilim_off) begin
            next_state.cfg.trip_delay = wdata[5:0];
          end
        end
        // (RULE22) Low scale not above high
        drive_ctrl_pkg::addr_fb_low: begin
          if ($signed(wdata) <= $signed(state.cfg.fb_high) &&
              $signed(wdata) >= $signed(drive_ctrl_pkg::fb_low_limit)) begin
            next_state.cfg.fb_low = wdata;
          end
        end
        drive_ctrl_pkg::addr_fb_high: begin
          if ($signed(wdata) >= $signed(state.cfg.fb_low)) begin
            next_state.cfg.fb_high = wdata;
          end
        end
        drive_ctrl_pkg::addr_fmax: begin
          next_state.cfg.fmax = wdata[15:0];
        end
        default: begin
        end
      endcase
    end

    if (read) begin
      case (addr)
        drive_ctrl_pkg::addr_sleep_time: next_state.rdata = 32'(state.cfg.sleep_time);
        drive_ctrl_pkg::addr_sleep_freq: next_state.rdata = 32'(state.cfg.sleep_freq);
        drive_ctrl_pkg::addr_wake_freq:  next_state.rdata = 32'(state.cfg.wake_freq);
        drive_ctrl_pkg::addr_boost:      next_state.rdata = 32'(state.cfg.boost);
        drive_ctrl_pkg::addr_fsw:        next_state.rdata = 32'(state.cfg.switch_rate);
        drive_ctrl_pkg::addr_modes: begin
          next_state.rdata = 32'({state.cfg.overheat_action,
                                  state.cfg.mains_action,
                                  state.cfg.no_load_action,
                                  state.cfg.noise_mode});
        end
        drive_ctrl_pkg::addr_ilim_delay: next_state.rdata = 32'(state.cfg.trip_delay);
        drive_ctrl_pkg::addr_fb_low:     next_state.rdata = state.cfg.fb_low;
        drive_ctrl_pkg::addr_fb_high:    next_state.rdata = state.cfg.fb_high;
        drive_ctrl_pkg::addr_fmax:       next_state.rdata = 32'(state.cfg.fmax);
        drive_ctrl_pkg::addr_status: begin
          next_state.rdata = 32'({state.sleep_count, state.ilim_count,
                                  state.ilim_trip,
                                  state.sleep_state == drive_ctrl_pkg::asleep,
                                  state.out.warning, state.out.alarm,
                                  state.out.motor_stop});
        end
        default: next_state.rdata = 32'h0000_0000;
      endcase
    end

    // (RULE25) Sleep barred for local or jog
    // (RULE4) Off value disables sleep
    sleep_ok = (state.cfg.sleep_time != drive_ctrl_pkg::sleep_off) &&
               !drive_in.local_or_jog;
    below = drive_in.out_freq < state.cfg.sleep_freq;

    case (state.sleep_state)
      drive_ctrl_pkg::run: begin
        next_state.sleep_count = 9'h000;
        // (RULE1) Start count below threshold
        if (sleep_ok && below) begin
          next_state.sleep_state = drive_ctrl_pkg::counting;
        end
      end
      drive_ctrl_pkg::counting: begin
        if (!sleep_ok || !below) begin
          // (RULE23) Rising frequency clears timer
          next_state.sleep_state = drive_ctrl_pkg::run;
          next_state.sleep_count = 9'h000;
        end else if (state.sleep_count >= state.cfg.sleep_time) begin
          // (RULE2) Expiry stops motor
          next_state.sleep_state = drive_ctrl_pkg::asleep;
        end else if (tick) begin
          // (RULE26) Whole-second counting
          next_state.sleep_count = state.sleep_count + 9'h001;
        end
      end
      drive_ctrl_pkg::asleep: begin
        next_state.sleep_count = 9'h000;
        // (RULE3) Wake on theoretical frequency
        if (drive_in.theo_freq > state.cfg.wake_freq || !sleep_ok) begin
          next_state.sleep_state = drive_ctrl_pkg::run;
        end
      end
      default: next_state.sleep_state = drive_ctrl_pkg::run;
    endcase

    // (RULE19) Count seconds at current limit
    if (drive_in.current >= drive_in.ilim &&
        state.cfg.trip_delay != drive_ctrl_pkg::ilim_off) begin
      if (state.ilim_count >= state.cfg.trip_delay) begin
        next_state.ilim_trip = 1'b1;
      end else if (tick) begin
        next_state.ilim_count = state.ilim_count + 6'h01;
      end
    end else begin
      // (RULE20) Off value never cuts out
      next_state.ilim_count = 6'h00;
    end

    // (RULE18) Overheat derate first lowers rate
    if (drive_in.overtemp && state.cfg.overheat_action) begin
      if (tick) next_state.heat_rate_low = 1'b1;
    end else begin
      next_state.heat_rate_low = 1'b0;
    end

    // (RULE9) Fixed mode uses programmed rate
    // (RULE13) Other modes also use the programmed rate
    rate = state.cfg.switch_rate;
    if (state.heat_rate_low) rate = drive_ctrl_pkg::fsw_min_khz10;
    next_state.out.active_switch_rate = rate;
    // (RULE11) Derate above 4.5 kHz, not adaptive
    next_state.out.derate_output =
      rate > drive_ctrl_pkg::derate_khz10 &&
      state.cfg.noise_mode != drive_ctrl_pkg::noise_adaptive;
    next_state.out.lc_protect =
      state.cfg.noise_mode == drive_ctrl_pkg::noise_lc;
    // (RULE10) Tenth of switching rate, 0.1 Hz units
    next_state.out.freq_clamp = min16(state.cfg.fmax, 16'(rate * 16'h0064));

    cur_lim = drive_in.ilim;
    // (RULE16) Mains derate to 30 percent
    if (drive_in.mains_fault &&
        state.cfg.mains_action == drive_ctrl_pkg::mains_derate) begin
      cur_lim = min16(cur_lim, pct_of(drive_in.rated_current,
                                      drive_ctrl_pkg::mains_derate_pct));
    end
    if (drive_in.overtemp && state.cfg.overheat_action &&
        state.out.active_switch_rate == drive_ctrl_pkg::fsw_min_khz10) begin
      cur_lim = min16(cur_lim, pct_of(drive_in.rated_current,
                                      drive_ctrl_pkg::mains_derate_pct));
    end
    next_state.out.current_clamp = cur_lim;

    // (RULE14) Low current trip action
    // (RULE15) Mains trip stops motor
    // (RULE17) Overheat trip with alarm
    stop_now = state.ilim_trip ||
      (drive_in.current < drive_in.low_current && !state.cfg.no_load_action) ||
      (drive_in.mains_fault &&
       state.cfg.mains_action == drive_ctrl_pkg::mains_trip) ||
      (drive_in.overtemp && !state.cfg.overheat_action);
    next_state.out.alarm = stop_now;
    next_state.out.motor_stop = stop_now ||
      state.sleep_state == drive_ctrl_pkg::asleep;
    // (RULE24) Sleep stop ramps down
    next_state.out.ramp_stop = state.sleep_state == drive_ctrl_pkg::asleep;
    next_state.out.warning =
      (drive_in.current < drive_in.low_current && state.cfg.no_load_action) ||
      (drive_in.mains_fault &&
       state.cfg.mains_action != drive_ctrl_pkg::mains_trip) ||
      (drive_in.overtemp && state.cfg.overheat_action);
    // (RULE8) Boost while counting, closed loop
    // (RULE7) Output tracks theoretical reference externally
    next_state.out.boost_pct =
      (drive_in.closed_loop &&
       state.sleep_state == drive_ctrl_pkg::counting) ?
      state.cfg.boost : drive_ctrl_pkg::pct_full;

    // (RULE21) Scaling independent of loop mode
    span = 48'(signed'(state.cfg.fb_high)) - 48'(signed'(state.cfg.fb_low));
    scaled = 48'(signed'(state.cfg.fb_low)) +
             ((span * signed'({1'b0, feedback_raw})) >>> 16);
    next_state.fb = scaled[31:0];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= '0;
      state.cfg.sleep_time <= drive_ctrl_pkg::sleep_off;
      state.cfg.sleep_freq <= drive_ctrl_pkg::sleep_default;
      state.cfg.wake_freq <= drive_ctrl_pkg::wake_default;
      state.cfg.boost <= drive_ctrl_pkg::boost_default;
      state.cfg.fmax <= drive_ctrl_pkg::wake_default;
      state.cfg.switch_rate <= drive_ctrl_pkg::derate_khz10;
      state.cfg.no_load_action <= 1'b1;
      state.cfg.trip_delay <= drive_ctrl_pkg::ilim_off;
      state.cfg.fb_high <= 32'h0001_86a0;
      state.out.boost_pct <= drive_ctrl_pkg::pct_full;
    end else begin
      state <= next_state;
    end
  end

  assign rdata = state.rdata;
  assign drive_out = state.out;
  assign feedback_scaled = state.fb;
endmodule

/* File: drive_sleep_and_protection_control_asserts.sv */
// Port checker for the drive sleep and protection block
module drive_sleep_and_protection_control_asserts #(
  parameter int unsigned tick_cycles = drive_ctrl_pkg::tick_cycles
) (
  input wire logic                          clk,
  input wire logic                          reset,
  input wire logic [3:0]                    addr,
  input wire logic [31:0]                   wdata,
  input wire logic                          write,
  input wire logic                          read,
  input wire logic [31:0]                   rdata,
  input wire drive_ctrl_pkg::drive_in_type  drive_in,
  input wire logic [15:0]                   feedback_raw,
  input wire drive_ctrl_pkg::drive_out_type drive_out,
  input wire logic [31:0]                   feedback_scaled
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  boost_open_a : assert property (
    !drive_in.closed_loop [*2] |=> drive_out.boost_pct == 8'h64)
    else $error("boost applied in open loop");
  freq_clamp_a : assert property (
    {16'h0000, drive_out.freq_clamp} <=
    drive_out.active_switch_rate * 32'h0000_0064)
    else $error("clamp above a tenth of switching");
  derate_low_a : assert property (
    drive_out.active_switch_rate <= 16'h002d |-> !drive_out.derate_output)
    else $error("derating at or below 4.5 kHz");
  alarm_stop_a : assert property (
    $rose(drive_out.alarm) |-> drive_out.motor_stop)
    else $error("alarm without motor stop");
  local_hold_a : assert property (
    drive_in.local_or_jog [*2] ##0 !drive_out.ramp_stop |=>
    !drive_out.ramp_stop)
    else $error("sleep entered under local or jog");
  sleep_cause_a : assert property (
    $rose(drive_out.ramp_stop) |-> !$past(drive_in.local_or_jog, 2))
    else $error("sleep stop after local or jog");
  lc_stable_a : assert property (
    !$past(write) && !$past(write, 2) |-> $stable(drive_out.lc_protect))
    else $error("filter flag changed without write");
  reset_out_a : assert property (
    $fell(reset) |-> drive_out.boost_pct == 8'h64 &&
    !drive_out.motor_stop && !drive_out.ramp_stop)
    else $error("outputs not at reset");
  rate_floor_a : assert property (
    drive_out.active_switch_rate != 16'h0000 |->
    drive_out.active_switch_rate >= 16'h0014)
    else $error("switching rate below floor");
endmodule

bind drive_sleep_and_protection_control
  drive_sleep_and_protection_control_asserts #(.tick_cycles(tick_cycles))
  i_drive_sleep_and_protection_control_asserts (.clk(clk), .reset(reset),
  .addr(addr), .wdata(wdata), .write(write), .read(read), .rdata(rdata),
  .drive_in(drive_in), .feedback_raw(feedback_raw),
  .drive_out(drive_out), .feedback_scaled(feedback_scaled));

/* File: motor_feedback_model.sv */
// Behavioural motor and process feedback transmitter
module motor_feedback_model (
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire drive_ctrl_pkg::drive_in_type  cmd,
  input  wire logic [15:0]                   raw_cmd,
  input  wire drive_ctrl_pkg::drive_out_type drive_out,
  output drive_ctrl_pkg::drive_in_type       drive_in,
  output logic [15:0]                        feedback_raw
);
  logic [15:0] speed;
  logic [15:0] next_speed;

  // Speed follows command, coasts down on stop
  always_comb begin
    next_speed = cmd.theo_freq;
    if (drive_out.motor_stop || drive_out.ramp_stop) begin
      next_speed = (speed > 16'h000a) ? speed - 16'h000a : 16'h0000;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      speed        <= 16'h0000;
      feedback_raw <= 16'h0000;
    end else begin
      speed        <= next_speed;
      feedback_raw <= raw_cmd;
    end
  end

  always_comb begin
    drive_in          = cmd;
    drive_in.out_freq = speed;
  end
endmodule

/* File: drive_sleep_and_protection_control_tb.sv */
// Self-checking bench for the drive sleep and protection block
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
  n_errors++; $display("CHECK FAILED %0t got %h exp %h", $time, got, exp); \
  end end
`define WAITC(c, n) for (wi = 0; wi < (n) && (c) !== 1'b1; wi++) \
  @(posedge clk); #1
module drive_sleep_and_protection_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned tc = 10;
  localparam drive_ctrl_pkg::drive_in_type base = '{out_freq: 16'h0000,
    theo_freq: 16'h01f4, current: 16'h0064, ilim: 16'h03e8,
    low_current: 16'h000a, rated_current: 16'h03e8, default: 1'b0};
  localparam logic [3:0] da [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
    4'h6, 4'h7, 4'h8, 4'ha, 4'hf};
  localparam logic [31:0] dd [11] = '{32'h0000_0000, 32'h0000_0000,
    32'h0000_01f4, 32'h0000_0064, 32'h0000_002d, 32'h0000_0004,
    32'h0000_003d, 32'h0000_0000, 32'h0001_86a0, 32'h0000_01f4,
    32'h0000_0000};
  localparam logic [3:0] ra [9] = '{4'h0, 4'h0, 4'h3, 4'h3, 4'h3, 4'h6,
    4'h5, 4'h1, 4'h2};
  localparam logic [31:0] rw [9] = '{32'h0000_012d, 32'h0000_012c,
    32'h0000_0000, 32'h0000_00c9, 32'h0000_00c8, 32'h0000_003e,
    32'h0000_0003, 32'h0000_0258, 32'h0000_0258};
  localparam logic [31:0] re [9] = '{32'h0000_0000, 32'h0000_012c,
    32'h0000_0064, 32'h0000_0064, 32'h0000_00c8, 32'h0000_003d,
    32'h0000_0004, 32'h0000_0000, 32'h0000_01f4};

  logic                          clk = 1'b0;
  logic                          reset = 1'b1;
  logic [3:0]                    addr = 4'h0;
  logic [31:0]                   wdata = 32'h0000_0000;
  logic                          write = 1'b0;
  logic                          read = 1'b0;
  logic [31:0]                   rdata;
  drive_ctrl_pkg::drive_in_type  cmd = base;
  drive_ctrl_pkg::drive_in_type  drive_in;
  drive_ctrl_pkg::drive_out_type drive_out;
  logic [15:0]                   raw_cmd = 16'h0000;
  logic [15:0]                   feedback_raw;
  logic [31:0]                   feedback_scaled;
  int                            n_errors = 0;
  int                            total_checks = 0;
  int                            wi;

  always #10 clk = ~clk;

  drive_sleep_and_protection_control #(.tick_cycles(tc))
    i_drive_sleep_and_protection_control (.clk(clk), .reset(reset),
    .addr(addr), .wdata(wdata), .write(write), .read(read), .rdata(rdata),
    .drive_in(drive_in), .feedback_raw(feedback_raw),
    .drive_out(drive_out), .feedback_scaled(feedback_scaled));

  motor_feedback_model i_motor_feedback_model (.clk(clk), .reset(reset),
    .cmd(cmd), .raw_cmd(raw_cmd), .drive_out(drive_out),
    .drive_in(drive_in), .feedback_raw(feedback_raw));

  task automatic tally_and_finish();
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic do_reset();
    reset   <= 1'b1;
    cmd     <= base;
    raw_cmd <= 16'h0000;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    write <= 1'b1;
    @(posedge clk);
    write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    read <= 1'b1;
    @(posedge clk);
    read <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    `CHK(v, e)
  endtask

  task automatic wake();
    cmd.theo_freq <= 16'h00fa;
    `WAITC(!drive_out.ramp_stop, 10);
    `CHK(drive_out.ramp_stop, 1'b0)
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    logic [31:0] v;
    do_reset();
    for (int i = 0; i < 11; i++) rdchk(da[i], dd[i]);
    `CHK(drive_out.boost_pct, 8'h64)
    for (int i = 0; i < 9; i++) begin
      wr(ra[i], rw[i]);
      rdchk(ra[i], re[i]);
    end
    // Sleep entry with boost, wake, timer clear
    do_reset();
    wr(4'h2, 32'h0000_00c8);
    wr(4'h1, 32'h0000_0064);
    wr(4'h3, 32'h0000_007d);
    wr(4'h0, 32'h0000_0003);
    cmd.closed_loop <= 1'b1;
    cmd.theo_freq   <= 16'h0032;
    cyc(12);
    `CHK(drive_out.ramp_stop, 1'b0)
    `CHK(drive_out.boost_pct, 8'h7d)
    `WAITC(drive_out.ramp_stop, 40);
    `CHK(drive_out.ramp_stop, 1'b1)
    rd(4'h9, v);
    `CHK(v[3], 1'b1)
    wake();
    cmd.theo_freq <= 16'h0032;
    cyc(15);
    cmd.theo_freq <= 16'h0096;
    cyc(5);
    cmd.theo_freq <= 16'h0032;
    cyc(18);
    `CHK(drive_out.ramp_stop, 1'b0)
    `WAITC(drive_out.ramp_stop, 40);
    `CHK(drive_out.ramp_stop, 1'b1)
    wake();
    // Local or jog blocks sleep, open loop allows it
    cmd.closed_loop  <= 1'b0;
    cmd.local_or_jog <= 1'b1;
    cmd.theo_freq    <= 16'h0032;
    cyc(50);
    `CHK(drive_out.ramp_stop, 1'b0)
    cmd.local_or_jog <= 1'b0;
    `WAITC(drive_out.ramp_stop, 40);
    `CHK(drive_out.ramp_stop, 1'b1)
    wake();
    wr(4'h0, 32'h0000_0000);
    cmd.theo_freq <= 16'h0032;
    cyc(50);
    `CHK(drive_out.ramp_stop, 1'b0)
    // Switching rate, clamp, derate, noise modes
    do_reset();
    wr(4'ha, 32'h0000_1388);
    wr(4'h5, 32'h0000_0005);
    wr(4'h4, 32'h0000_001e);
    cyc(3);
    `CHK(drive_out.active_switch_rate, 16'h001e)
    `CHK(drive_out.freq_clamp, 16'h0bb8)
    `CHK(drive_out.derate_output, 1'b0)
    wr(4'h4, 32'h0000_0032);
    cyc(3);
    `CHK(drive_out.derate_output, 1'b1)
    wr(4'h5, 32'h0000_0004);
    cyc(3);
    `CHK(drive_out.derate_output, 1'b0)
    wr(4'h5, 32'h0000_0006);
    cyc(3);
    `CHK(drive_out.lc_protect, 1'b1)
    // No-load trip, then no-load warning
    wr(4'h5, 32'h0000_0000);
    cmd.current <= 16'h0005;
    `WAITC(drive_out.motor_stop, 20);
    `CHK(drive_out.motor_stop, 1'b1)
    do_reset();
    cmd.current <= 16'h0005;
    `WAITC(drive_out.warning, 20);
    `CHK(drive_out.warning, 1'b1)
    `CHK(drive_out.motor_stop, 1'b0)
    // Mains failure actions
    for (int m = 0; m < 3; m++) begin
      do_reset();
      wr(4'h5, {27'h000_0000, m[1:0], 3'h4});
      cmd.mains_fault <= 1'b1;
      cyc(55);
      `CHK(drive_out.motor_stop, 1'(m == 0))
      if (m != 0) `CHK(drive_out.warning, 1'b1)
      if (m == 1) `CHK(drive_out.current_clamp, 16'h012c)
    end
    // Overtemperature trip, then derate
    do_reset();
    cmd.overtemp <= 1'b1;
    `WAITC(drive_out.alarm, 20);
    `CHK(drive_out.alarm, 1'b1)
    `CHK(drive_out.motor_stop, 1'b1)
    do_reset();
    wr(4'h5, 32'h0000_0024);
    cmd.overtemp <= 1'b1;
    `WAITC(drive_out.active_switch_rate == 16'h0014, 15);
    `CHK(drive_out.active_switch_rate, 16'h0014)
    `CHK(drive_out.warning, 1'b1)
    `WAITC(drive_out.current_clamp == 16'h012c, 25);
    `CHK(drive_out.current_clamp, 16'h012c)
    // Current limit cut-out off, then two seconds
    do_reset();
    cmd.current <= 16'h03e8;
    cyc(80);
    rd(4'h9, v);
    `CHK(v[4], 1'b0)
    wr(4'h6, 32'h0000_0002);
    `WAITC(drive_out.motor_stop, 40);
    `CHK(drive_out.motor_stop, 1'b1)
    rd(4'h9, v);
    `CHK(v[4], 1'b1)
    // Feedback scaling in open loop
    do_reset();
    wr(4'h8, 32'h0000_1388);
    wr(4'h7, 32'hffff_ec78);
    cyc(4);
    `CHK(feedback_scaled, 32'hffff_ec78)
    raw_cmd <= 16'h8000;
    cyc(4);
    `CHK(feedback_scaled, 32'h0000_0000)
    wr(4'h7, 32'h0000_1770);
    rdchk(4'h7, 32'hffff_ec78);
    tally_and_finish();
  end
endmodule
